// ---- src/info_rom_regs.vh ----
/*
  offsets, field positions and default contents of the processor information rom
  feature region (byte offsets 38h..7Ch of the 128-byte information rom).
  assumes byte addressing on an 8-bit offset; no clock or reset is implied here.
*/
`ifndef INFO_ROM_REGS_VH
`define INFO_ROM_REGS_VH

// region bounds
`define ROM_REGION_LO 8'h38
`define ROM_REGION_HI 8'h7C
`define ROM_INFO_TOP 8'h7F

// register offsets
`define OFS_PART_NUMBER_STRING 8'h38
`define OFS_PART_NUMBER_END 8'h3E
`define OFS_RESERVED_BLOCK_SIX 8'h3F
`define OFS_UNIT_SIGNATURE 8'h4D
`define OFS_UNIT_SIGNATURE_END 8'h54
`define OFS_RESERVED_BLOCK_SEVEN 8'h55
`define OFS_PART_SECTION_CHECKSUM 8'h6F
`define OFS_RESERVED_BYTE_EIGHT 8'h70
`define OFS_RESERVED_WORD_NINE 8'h71
`define OFS_THERMAL_SECTION_CHECKSUM 8'h73
`define OFS_CORE_FEATURE_FLAGS 8'h74
`define OFS_PACKAGE_FEATURE_FLAGS 8'h78
`define OFS_CORE_THREAD_COUNT 8'h79
`define OFS_EXTRA_FEATURE_FLAGS 8'h7A
`define OFS_THERMAL_ADJUST_FACTORS 8'h7B

// package feature flag bits
`define PFF_MULTI_CORE_BIT 7
`define PFF_SERIAL_SIG_BIT 6
`define PFF_ELECTRONIC_SIG_BIT 5
`define PFF_THERMAL_SENSOR_BIT 4
`define PFF_RESERVED_BIT 3
`define PFF_SCRATCH_MEM_BIT 2
`define PFF_CORE_VID_BIT 1
`define PFF_L3_CACHE_BIT 0

// core thread count fields
`define CTC_CORES_MSB 3
`define CTC_CORES_LSB 2
`define CTC_THREADS_MSB 1
`define CTC_THREADS_LSB 0

// extra feature flags reserved bit
`define XFF_RESERVED_BIT 7

// thermal adjust factor fields
`define TAF_CORRECTION_MSB 15
`define TAF_CORRECTION_LSB 8
`define TAF_TARGET_MSB 7
`define TAF_TARGET_LSB 0

// padding character and default contents
`define ASCII_SPACE 8'h20
`define DEF_PART_NUMBER 56'h20_20_20_20_20_20_20
`define DEF_UNIT_SIGNATURE 64'h0000_0000_0000_0000
`define DEF_CORE_FEATURE_FLAGS 32'h0000_0000
`define DEF_PACKAGE_FEATURE_FLAGS 8'h00
`define DEF_CORE_THREAD_COUNT 8'h00
`define DEF_EXTRA_FEATURE_FLAGS 8'h00
`define DEF_THERMAL_ADJUST 16'h0000
`define DEF_RESERVED_BYTE 8'h00

`endif

// ---- src/info_rom_feature.v ----
/*
  read-only processor information rom, feature region 38h..7Ch.
  contents are fixed by parameters at build time; the read port is the
  memory component's byte port, driven by the smbus front end outside this
  block, which gives an address and strobes a read or a write.
  assumes a single clock mclk_i and the byte port synchronous to it.
*/
`include "info_rom_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module info_rom_feature #(
  parameter [55:0] PART_CHARS = `DEF_PART_NUMBER,
  parameter [3:0] PART_LEN = 4'h7,
  // signature value is arbitrary
  parameter [63:0] UNIT_SIG = `DEF_UNIT_SIGNATURE,
  parameter SIG_IS_SERIAL = 0,
  parameter SIG_IS_ELECTRONIC = 1,
  parameter MULTI_CORE = 1,
  parameter THERMAL_SENSOR = 1,
  parameter SCRATCH_MEM = 1,
  parameter CORE_VID = 1,
  parameter L3_CACHE = 1,
  parameter [1:0] CORE_CODE = 2'h2,
  parameter [1:0] THREAD_CODE = 2'h2,
  parameter [31:0] EDX_FLAGS = `DEF_CORE_FEATURE_FLAGS,
  parameter [6:0] EXTRA_FLAGS = 7'h00,
  parameter [7:0] CORR_FACTOR = 8'h00,
  parameter [7:0] TEMP_TARGET = 8'h00
)(
  // clock and reset
  input wire mclk_i,
  input wire rst_b_i,
  // byte port
  input wire [7:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  // read answer
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output wire in_region_o,
  output wire wr_ignored_o
);

  // part number with leading space padding; shorter strings sit in the high characters
  wire [55:0] part_padded;
  wire [63:0] sig_bytes;
  wire [7:0] pkg_flags;
  wire [7:0] ct_count;
  wire [7:0] xflags;
  wire [15:0] taf_word;
  wire [7:0] resv_byte;
  wire [7:0] part_sum;
  wire [7:0] therm_sum;
  wire [7:0] part_cks;
  wire [7:0] therm_cks;
  reg [7:0] byte_sel;
  reg [7:0] rdata_nxt;
  reg in_range;

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1)
    begin : pad
      // character g+1 at offset 38h+g; padding fills the leading positions
      // split by generate-if so no negative part-select is ever elaborated
      if (g < (7 - PART_LEN))
      begin : lead
        assign part_padded[8*g+7:8*g] = `ASCII_SPACE;
      end
      else
      begin : chars
        assign part_padded[8*g+7:8*g] = PART_CHARS[8*(g+PART_LEN-7) +: 8];
      end
    end
  endgenerate

  assign sig_bytes = UNIT_SIG;
  assign resv_byte = `DEF_RESERVED_BYTE;

  // electronic flag is dropped if both are requested, keeping them exclusive
  assign pkg_flags[`PFF_MULTI_CORE_BIT] = (MULTI_CORE != 0);
  assign pkg_flags[`PFF_SERIAL_SIG_BIT] = (SIG_IS_SERIAL != 0);
  assign pkg_flags[`PFF_ELECTRONIC_SIG_BIT] = (SIG_IS_ELECTRONIC != 0) &&
    (SIG_IS_SERIAL == 0);
  assign pkg_flags[`PFF_THERMAL_SENSOR_BIT] = (THERMAL_SENSOR != 0);
  assign pkg_flags[`PFF_RESERVED_BIT] = 1'b0;
  assign pkg_flags[`PFF_SCRATCH_MEM_BIT] = (SCRATCH_MEM != 0);
  assign pkg_flags[`PFF_CORE_VID_BIT] = (CORE_VID != 0);
  assign pkg_flags[`PFF_L3_CACHE_BIT] = (L3_CACHE != 0);

  assign ct_count = {4'h0, CORE_CODE, THREAD_CODE};
  assign xflags = {1'b0, EXTRA_FLAGS};
  assign taf_word = {CORR_FACTOR, TEMP_TARGET};

  // section sums are constant folded; no adder survives synthesis
  // every byte of 38h..6Eh is summed, reserved ones too, so a non-zero default stays covered
  assign part_sum =
    part_padded[7:0] +
    part_padded[15:8] +
    part_padded[23:16] +
    part_padded[31:24] +
    part_padded[39:32] +
    part_padded[47:40] +
    part_padded[55:48] +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    sig_bytes[7:0] +
    sig_bytes[15:8] +
    sig_bytes[23:16] +
    sig_bytes[31:24] +
    sig_bytes[39:32] +
    sig_bytes[47:40] +
    sig_bytes[55:48] +
    sig_bytes[63:56] +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte +
    resv_byte;
  assign part_cks = 8'h00 - part_sum;
  assign therm_sum = resv_byte + resv_byte + resv_byte;
  assign therm_cks = 8'h00 - therm_sum;

  always @*
  begin
    byte_sel = resv_byte;
    in_range = (addr_i >= `ROM_REGION_LO) && (addr_i <= `ROM_REGION_HI);
    // every rom offset spelled out so a misplaced byte is visible in one place
    case (addr_i)
      8'h00: byte_sel = resv_byte;
      8'h01: byte_sel = resv_byte;
      8'h02: byte_sel = resv_byte;
      8'h03: byte_sel = resv_byte;
      8'h04: byte_sel = resv_byte;
      8'h05: byte_sel = resv_byte;
      8'h06: byte_sel = resv_byte;
      8'h07: byte_sel = resv_byte;
      8'h08: byte_sel = resv_byte;
      8'h09: byte_sel = resv_byte;
      8'h0A: byte_sel = resv_byte;
      8'h0B: byte_sel = resv_byte;
      8'h0C: byte_sel = resv_byte;
      8'h0D: byte_sel = resv_byte;
      8'h0E: byte_sel = resv_byte;
      8'h0F: byte_sel = resv_byte;
      8'h10: byte_sel = resv_byte;
      8'h11: byte_sel = resv_byte;
      8'h12: byte_sel = resv_byte;
      8'h13: byte_sel = resv_byte;
      8'h14: byte_sel = resv_byte;
      8'h15: byte_sel = resv_byte;
      8'h16: byte_sel = resv_byte;
      8'h17: byte_sel = resv_byte;
      8'h18: byte_sel = resv_byte;
      8'h19: byte_sel = resv_byte;
      8'h1A: byte_sel = resv_byte;
      8'h1B: byte_sel = resv_byte;
      8'h1C: byte_sel = resv_byte;
      8'h1D: byte_sel = resv_byte;
      8'h1E: byte_sel = resv_byte;
      8'h1F: byte_sel = resv_byte;
      8'h20: byte_sel = resv_byte;
      8'h21: byte_sel = resv_byte;
      8'h22: byte_sel = resv_byte;
      8'h23: byte_sel = resv_byte;
      8'h24: byte_sel = resv_byte;
      8'h25: byte_sel = resv_byte;
      8'h26: byte_sel = resv_byte;
      8'h27: byte_sel = resv_byte;
      8'h28: byte_sel = resv_byte;
      8'h29: byte_sel = resv_byte;
      8'h2A: byte_sel = resv_byte;
      8'h2B: byte_sel = resv_byte;
      8'h2C: byte_sel = resv_byte;
      8'h2D: byte_sel = resv_byte;
      8'h2E: byte_sel = resv_byte;
      8'h2F: byte_sel = resv_byte;
      8'h30: byte_sel = resv_byte;
      8'h31: byte_sel = resv_byte;
      8'h32: byte_sel = resv_byte;
      8'h33: byte_sel = resv_byte;
      8'h34: byte_sel = resv_byte;
      8'h35: byte_sel = resv_byte;
      8'h36: byte_sel = resv_byte;
      8'h37: byte_sel = resv_byte;
      `OFS_PART_NUMBER_STRING: byte_sel = part_padded[7:0];
      8'h39: byte_sel = part_padded[15:8];
      8'h3A: byte_sel = part_padded[23:16];
      8'h3B: byte_sel = part_padded[31:24];
      8'h3C: byte_sel = part_padded[39:32];
      8'h3D: byte_sel = part_padded[47:40];
      `OFS_PART_NUMBER_END: byte_sel = part_padded[55:48];
      `OFS_RESERVED_BLOCK_SIX: byte_sel = resv_byte;
      8'h40: byte_sel = resv_byte;
      8'h41: byte_sel = resv_byte;
      8'h42: byte_sel = resv_byte;
      8'h43: byte_sel = resv_byte;
      8'h44: byte_sel = resv_byte;
      8'h45: byte_sel = resv_byte;
      8'h46: byte_sel = resv_byte;
      8'h47: byte_sel = resv_byte;
      8'h48: byte_sel = resv_byte;
      8'h49: byte_sel = resv_byte;
      8'h4A: byte_sel = resv_byte;
      8'h4B: byte_sel = resv_byte;
      8'h4C: byte_sel = resv_byte;
      `OFS_UNIT_SIGNATURE: byte_sel = sig_bytes[7:0];
      8'h4E: byte_sel = sig_bytes[15:8];
      8'h4F: byte_sel = sig_bytes[23:16];
      8'h50: byte_sel = sig_bytes[31:24];
      8'h51: byte_sel = sig_bytes[39:32];
      8'h52: byte_sel = sig_bytes[47:40];
      8'h53: byte_sel = sig_bytes[55:48];
      `OFS_UNIT_SIGNATURE_END: byte_sel = sig_bytes[63:56];
      `OFS_RESERVED_BLOCK_SEVEN: byte_sel = resv_byte;
      8'h56: byte_sel = resv_byte;
      8'h57: byte_sel = resv_byte;
      8'h58: byte_sel = resv_byte;
      8'h59: byte_sel = resv_byte;
      8'h5A: byte_sel = resv_byte;
      8'h5B: byte_sel = resv_byte;
      8'h5C: byte_sel = resv_byte;
      8'h5D: byte_sel = resv_byte;
      8'h5E: byte_sel = resv_byte;
      8'h5F: byte_sel = resv_byte;
      8'h60: byte_sel = resv_byte;
      8'h61: byte_sel = resv_byte;
      8'h62: byte_sel = resv_byte;
      8'h63: byte_sel = resv_byte;
      8'h64: byte_sel = resv_byte;
      8'h65: byte_sel = resv_byte;
      8'h66: byte_sel = resv_byte;
      8'h67: byte_sel = resv_byte;
      8'h68: byte_sel = resv_byte;
      8'h69: byte_sel = resv_byte;
      8'h6A: byte_sel = resv_byte;
      8'h6B: byte_sel = resv_byte;
      8'h6C: byte_sel = resv_byte;
      8'h6D: byte_sel = resv_byte;
      8'h6E: byte_sel = resv_byte;
      `OFS_PART_SECTION_CHECKSUM: byte_sel = part_cks;
      `OFS_RESERVED_BYTE_EIGHT: byte_sel = resv_byte;
      `OFS_RESERVED_WORD_NINE: byte_sel = resv_byte;
      8'h72: byte_sel = resv_byte;
      `OFS_THERMAL_SECTION_CHECKSUM: byte_sel = therm_cks;
      `OFS_CORE_FEATURE_FLAGS: byte_sel = EDX_FLAGS[7:0];
      8'h75: byte_sel = EDX_FLAGS[15:8];
      8'h76: byte_sel = EDX_FLAGS[23:16];
      8'h77: byte_sel = EDX_FLAGS[31:24];
      `OFS_PACKAGE_FEATURE_FLAGS: byte_sel = pkg_flags;
      `OFS_CORE_THREAD_COUNT: byte_sel = ct_count;
      `OFS_EXTRA_FEATURE_FLAGS: byte_sel = xflags;
      `OFS_THERMAL_ADJUST_FACTORS: byte_sel = taf_word[`TAF_TARGET_MSB:`TAF_TARGET_LSB];
      8'h7C: byte_sel = taf_word[`TAF_CORRECTION_MSB:`TAF_CORRECTION_LSB];
      8'h7D: byte_sel = resv_byte;
      8'h7E: byte_sel = resv_byte;
      8'h7F: byte_sel = resv_byte;
      default: byte_sel = resv_byte;
    endcase
    // outside the region this block answers zero
    rdata_nxt = in_range ? byte_sel : 8'h00;
  end

  assign in_region_o = (addr_i >= `ROM_REGION_LO) && (addr_i <= `ROM_REGION_HI);
  // write strobe only reported; no storage exists to change
  assign wr_ignored_o = wr_i && (addr_i <= `ROM_INFO_TOP);

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      if (rd_i)
      begin
        rdata_o <= rdata_nxt;
      end
    end
  end

  // wdata_i is deliberately unused: the contents are permanent
  wire unused_wdata = ^wdata_i;

endmodule

`default_nettype wire

// ---- sim/info_rom_feature_checker.sv ----
/* concurrent checks on the info rom byte port.
   assumes one clock mclk_i and async active-low reset rst_b_i. */
`timescale 1ns/100ps
`default_nettype none
module info_rom_feature_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // byte port
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // read answer
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic in_region_o,
  input wire logic wr_ignored_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_flag_rd;
    rd_i && addr_i == 8'h78;
  endsequence
  sequence s_out_rd;
    rd_i && (addr_i < 8'h38 || addr_i > 8'h7C);
  endsequence
  chk_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read gave no answer");
  chk_answer_cause: assert property (rvalid_o |-> $past(rd_i))
    else $error("answer without read");
  chk_region_flag: assert property (in_region_o == (addr_i >= 8'h38 && addr_i <= 8'h7C))
    else $error("region flag wrong");
  chk_write_flag: assert property (wr_ignored_o == (wr_i && addr_i <= 8'h7F))
    else $error("write flag wrong");
  chk_data_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without read");
  chk_outside_zero: assert property (s_out_rd |=> rdata_o == 8'h00)
    else $error("outside byte not zero");
  chk_sig_exclusive: assert property (s_flag_rd |=> !(rdata_o[6] && rdata_o[5]))
    else $error("both signature flags set");
  chk_thermal_rsvd: assert property (rd_i && addr_i inside {[8'h70:8'h72]} |=> rdata_o == 8'h00)
    else $error("thermal reserved not zero");
  chk_thermal_cks: assert property (rd_i && addr_i == 8'h73 |=> rdata_o == 8'h00)
    else $error("thermal checksum wrong");
endmodule
bind info_rom_feature info_rom_feature_checker i_info_rom_feature_checker (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .in_region_o(in_region_o), .wr_ignored_o(wr_ignored_o));
`default_nettype wire

// ---- sim/smbus_host_model.sv ----
/* host side of the rom byte port: reads and writes bytes.
   assumes requests start just after a rising edge of mclk_i. */
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
  // clock
  input wire logic mclk_i,
  // requests
  output logic [7:0] addr_o = 8'h00,
  output logic rd_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00,
  // answers
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // rd stays high on return so calls run back to back
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    addr_o = a;
    wr_o = 1'b0;
    rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    addr_o = a;
    wdata_o = wd;
    rd_o = 1'b0;
    wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic idle();
    rd_o = 1'b0;
    wr_o = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- sim/info_rom_feature_tb.sv ----
/* self-checking bench for the info rom feature region.
   assumes the host model drives the byte port. */
`timescale 1ns/100ps
`default_nettype none
module info_rom_feature_tb;
  localparam logic [55:0] PART = 56'h47_46_45_44_43_42_41;
  // signature value is arbitrary
  localparam logic [63:0] SIG = 64'h88776655_44332211;
  localparam logic [31:0] EDX = 32'hDEADBEEF;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic rd, wr, rvalid, in_region, wr_ign;
  logic [7:0] d;
  logic v;
  int errors = 0;
  int compares = 0;
  always #4 mclk_i = ~mclk_i;
  smbus_host_model i_smbus_host_model (.mclk_i(mclk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  // serial and electronic both requested: serial must win and keep the flags exclusive
  info_rom_feature #(.PART_CHARS(PART), .UNIT_SIG(SIG), .SIG_IS_SERIAL(1), .THREAD_CODE(2'h1),
    .EDX_FLAGS(EDX), .EXTRA_FLAGS(7'h55), .CORR_FACTOR(8'hA5), .TEMP_TARGET(8'h5A))
    i_info_rom_feature (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr), .rd_i(rd),
    .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .in_region_o(in_region),
    .wr_ignored_o(wr_ign));
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    logic [7:0] s;
    s = 8'h00;
    if (a >= 8'h38 && a <= 8'h3E) s = 8'(PART >> 8 * (a - 8'h38));
    if (a >= 8'h4D && a <= 8'h54) s = 8'(SIG >> 8 * (a - 8'h4D));
    if (a >= 8'h74 && a <= 8'h77) s = 8'(EDX >> 8 * (a - 8'h74));
    if (a == 8'h78) s = 8'hD7;
    if (a == 8'h79) s = 8'h09;
    if (a == 8'h7A) s = 8'h55;
    if (a == 8'h7B) s = 8'h5A;
    if (a == 8'h7C) s = 8'hA5;
    // checksum negates the byte sum of its section
    if (a == 8'h6F) for (int k = 8'h38; k < 8'h6F; k++) s = s - exp_byte(k[7:0]);
    return s;
  endfunction
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, want, got);
    end
  endtask
  task automatic t_map();
    for (int a = 8'h30; a <= 8'h80; a++)
    begin
      i_smbus_host_model.rd(a[7:0], d, v);
      chk("rvalid", {7'h00, v}, 8'h01);
      chk("region", {7'h00, in_region}, {7'h00, a >= 8'h38 && a <= 8'h7C});
      chk("byte", d, exp_byte(a[7:0]));
    end
    i_smbus_host_model.idle();
  endtask
  task automatic t_write();
    logic [7:0] list [4] = '{8'h38, 8'h78, 8'h6F, 8'h90};
    foreach (list[i])
    begin
      i_smbus_host_model.wr(list[i], ~exp_byte(list[i]));
      chk("wr_ignored", {7'h00, wr_ign}, {7'h00, list[i] <= 8'h7F});
      i_smbus_host_model.idle();
      i_smbus_host_model.rd(list[i], d, v);
      chk("after write", d, exp_byte(list[i]));
      i_smbus_host_model.idle();
    end
  endtask
  task automatic t_reset();
    i_smbus_host_model.rd(8'h78, d, v);
    rst_b_i = 1'b0;
    #1;
    chk("reset data", rdata, 8'h00);
    chk("reset valid", {7'h00, rvalid}, 8'h00);
    i_smbus_host_model.idle();
    rst_b_i = 1'b1;
    i_smbus_host_model.idle();
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    t_map();
    t_write();
    t_reset();
    t_map();
    summarize();
  end
endmodule
`default_nettype wire
